// ==== pkg/pdb_pkg.sv ====
// Package with register map, field positions and types of the peripheral disable bank.
package pdb_pkg;

	// Byte address of the base register and its three aliases.
	localparam logic [7:0]  PDB_ADDR_BASE = 8'hC0;
	localparam logic [7:0]  PDB_ADDR_CLR  = 8'hC4;
	localparam logic [7:0]  PDB_ADDR_SET  = 8'hC8;
	localparam logic [7:0]  PDB_ADDR_INV  = 8'hCC;

	// Documented reset value; variants may override it through a parameter.
	localparam logic [31:0] PDB_RESET_VALUE = 32'h00000000;

	// Field positions of the disable bits.
	localparam int PDB_BIT_QSPI  = 29;
	localparam int PDB_BIT_RTCAL = 16;
	localparam int PDB_BIT_CORE  = 8;
	localparam int PDB_BIT_CONV  = 7;
	localparam int PDB_BIT_ACMP  = 6;
	localparam int PDB_BIT_LVD   = 4;
	localparam int PDB_BIT_LPA   = 3;
	localparam int PDB_BIT_MPA   = 2;
	localparam int PDB_BIT_SRR   = 1;
	localparam int PDB_BIT_MESH  = 0;

	// Mask of implemented bits; every other position reads zero.
	localparam logic [31:0] PDB_IMPL_MASK = 32'h200101DF;

	// Number of peripherals gated by the bank.
	localparam int PDB_NUM_PERIPH = 9;

	// Register operations selected by the address.
	typedef enum logic [1:0]
	{
		PDB_OP_WRITE = 2'b00,
		PDB_OP_CLEAR = 2'b01,
		PDB_OP_SET   = 2'b10,
		PDB_OP_INV   = 2'b11
	} pdb_op_t;

	// Per-peripheral controls that travel together.
	typedef struct packed
	{
		logic in_reset;
		logic clk_enable;
	} pdb_gate_t;

endpackage : pdb_pkg

// ==== rtl/pdb_bank.sv ====
// Peripheral disable register bank with lock, clear, set and invert aliases.
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module pdb_bank
	import pdb_pkg::*;
#(
	parameter logic [31:0] RESET_VALUE = PDB_RESET_VALUE
)
(
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	input  wire logic        WRITE_LOCK,
	output logic [31:0]      RDATA,
	output logic [31:0]      DISABLE_BITS,
	output logic             RT_CALENDAR_OFF,
	output pdb_gate_t [8:0]  PERIPH_GATE
);

	// Behaviour over time, seen from the bus.
	// A write strobe that names the base register or one of its three aliases changes
	// the register at that same edge, unless the lock input is high at that edge.
	// The register itself stays internal. Every visible output is a flip-flop fed from it,
	// so the raw copy and the calendar flag trail the register by one cycle.
	// The gate cells are such flip-flops too, fed from the register, so a peripheral's reset and clock enable
	// change one edge after the write was taken; a short glitch-free delay was
	// preferred to gating clocks straight from the register.
	// Read data appear in the cycle after the read strobe and fall back to zero after it,
	// so a bus that combines several slaves needs no extra select here.
	// Limitation: the bank cannot see the peripherals' interrupt flags. Software has to
	// clear them before it sets a disable bit, or the peripheral is stopped mid-request.
	// Limitation: there is no byte-lane write; every write carries a whole word, and bits
	// without a peripheral are dropped on the way in.

	logic [31:0] disable_q;  // The disable register itself.
	logic [31:0] disable_d;  // Its next value.
	logic        hit;        // Write hits one of the four addresses.
	pdb_op_t     op;         // Operation chosen by the address.
	logic [31:0] rd_d;       // Read data to be registered.

	// Address decode of the base register and its aliases.
	// Any other address leaves hit low, so a stray write is simply ignored.
	// The decode is shared by reads and writes to keep the two views consistent.
	always_comb
	begin
		hit = 1'b1;
		op  = PDB_OP_WRITE;
		unique case (ADDR)
			PDB_ADDR_BASE: op = PDB_OP_WRITE;
			PDB_ADDR_CLR:  op = PDB_OP_CLEAR;
			PDB_ADDR_SET:  op = PDB_OP_SET;
			PDB_ADDR_INV:  op = PDB_OP_INV;
			default:       hit = 1'b0;
		endcase
	end

	// Next value: only implemented bits are ever changed.
	// Masking after the operation means no alias can ever raise a reserved bit.
	// The operation is computed every cycle; the write enable below picks it up.
	always_comb
	begin
		disable_d = disable_q;
		unique case (op)
			PDB_OP_WRITE: disable_d = WDATA;
			PDB_OP_CLEAR: disable_d = disable_q & ~WDATA;
			PDB_OP_SET:   disable_d = disable_q | WDATA;
			PDB_OP_INV:   disable_d = disable_q ^ WDATA;
		endcase
		disable_d = disable_d & PDB_IMPL_MASK;
	end

	// Register update; the lock input blocks every form of write.
	// The lock is sampled at the same edge as the strobe, so a lock raised in the
	// cycle of a write already protects that write.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			disable_q <= RESET_VALUE & PDB_IMPL_MASK;
		end
		else if (WR && hit && !WRITE_LOCK)
		begin
			disable_q <= disable_d;
		end
	end

	// All four addresses read back the disable register; others read zero.
	assign rd_d = (hit ? disable_q : 32'h00000000);

	// Read data stand only in the cycle after the read strobe.
	// Returning zero between reads lets the read data be combined with other
	// slaves on a shared return path without a multiplexer.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			RDATA <= 32'h00000000;
		end
		else
		begin
			RDATA <= RD ? rd_d : 32'h00000000;
		end
	end

	// Raw bits out, and the calendar flag which has no effect here.
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			DISABLE_BITS    <= 32'h00000000;
			RT_CALENDAR_OFF <= 1'b0;
		end
		else
		begin
			DISABLE_BITS    <= disable_q;
			RT_CALENDAR_OFF <= disable_q[PDB_BIT_RTCAL];
		end
	end

	// Gated peripherals in index order: mesh, short-range, MPA, LPA, LVD,
	// comparator, converter controller, shared core, quad serial memory.
	logic [8:0] gate_src;
	assign gate_src = {disable_q[PDB_BIT_QSPI],
	                   disable_q[PDB_BIT_CORE],
	                   disable_q[PDB_BIT_CONV],
	                   disable_q[PDB_BIT_ACMP],
	                   disable_q[PDB_BIT_LVD],
	                   disable_q[PDB_BIT_LPA],
	                   disable_q[PDB_BIT_MPA],
	                   disable_q[PDB_BIT_SRR],
	                   disable_q[PDB_BIT_MESH]};

	// One gate cell per peripheral; the shared core gate also covers its
	// shared converter resources downstream.
	genvar g;
	generate
		for (g = 0; g < PDB_NUM_PERIPH; g++)
		begin : g_gate
			pdb_gate u_gate
			(
				.clk         (CLOCK),
				.rst         (RESET),
				.disable_bit (gate_src[g]),
				.gate        (PERIPH_GATE[g])
			);
		end
	endgenerate

	// Locked writes must leave the register unchanged.
	AST_LOCK_HOLDS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && WRITE_LOCK) |=> $stable(disable_q))
		else $error("Locked write changed the register.");

	// A set alias write sets the implemented bits written.
	AST_SET_ALIAS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_SET)
		|=> ((disable_q & $past(WDATA) & PDB_IMPL_MASK) == ($past(WDATA) & PDB_IMPL_MASK)))
		else $error("Set alias failed to set bits.");

	// A clear alias write clears the bits written.
	AST_CLR_ALIAS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_CLR) |=> ((disable_q & $past(WDATA)) == 32'h00000000))
		else $error("Clear alias failed to clear bits.");

	// An invert alias write flips the written bits.
	AST_INV_ALIAS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_INV)
		|=> (disable_q == (($past(disable_q) ^ $past(WDATA)) & PDB_IMPL_MASK)))
		else $error("Invert alias result wrong.");

	// Unassigned bits never become one.
	AST_RESERVED_ZERO: assert property (@(posedge CLOCK) disable iff (RESET)
		(disable_q & ~PDB_IMPL_MASK) == 32'h00000000)
		else $error("Reserved bit set.");

	// The quad serial memory gate is held off one cycle after bit 29 rises.
	AST_QSPI_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_QSPI]) |=> (PERIPH_GATE[8].in_reset && !PERIPH_GATE[8].clk_enable))
		else $error("Quad serial memory not held off.");

	// Mesh radio gate follows bit 0 and releases with its clock.
	AST_MESH_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$fell(disable_q[PDB_BIT_MESH]) |=> (!PERIPH_GATE[0].in_reset && PERIPH_GATE[0].clk_enable))
		else $error("Mesh radio not released.");

	// Calendar flag tracks bit 16 one cycle later.
	AST_CAL_FLAG: assert property (@(posedge CLOCK) disable iff (RESET)
		##1 (RT_CALENDAR_OFF == $past(disable_q[PDB_BIT_RTCAL])))
		else $error("Calendar flag mismatch.");

	// Unmapped reads answer zero in the next cycle.
	AST_UNMAPPED_READ: assert property (@(posedge CLOCK) disable iff (RESET)
		(RD && !hit) |=> (RDATA == 32'h00000000))
		else $error("Unmapped read not zero.");

	// A plain write to the base address loads every implemented bit written.
	AST_BASE_WRITE: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_BASE)
		|=> (disable_q == ($past(WDATA) & PDB_IMPL_MASK)))
		else $error("Base write did not load the register.");

	// A clear alias write leaves every bit that was not written alone.
	AST_CLR_KEEPS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_CLR)
		|=> (disable_q == ($past(disable_q) & ~$past(WDATA) & PDB_IMPL_MASK)))
		else $error("Clear alias disturbed other bits.");

	// A set alias write leaves every bit that was not written alone.
	AST_SET_KEEPS: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !WRITE_LOCK && ADDR == PDB_ADDR_SET)
		|=> (disable_q == (($past(disable_q) | $past(WDATA)) & PDB_IMPL_MASK)))
		else $error("Set alias disturbed other bits.");

	// A write to any other address is dropped without a trace.
	AST_UNMAPPED_WRITE: assert property (@(posedge CLOCK) disable iff (RESET)
		(WR && !hit) |=> $stable(disable_q))
		else $error("Unmapped write changed the register.");

	// Every mapped read returns the register as it stood when the strobe was taken.
	AST_READ_DATA: assert property (@(posedge CLOCK) disable iff (RESET)
		(RD && hit) |=> (RDATA == $past(disable_q)))
		else $error("Read data differ from the register.");

	// Read data last one cycle; without a read strobe the bus reads zero.
	AST_READ_IDLE: assert property (@(posedge CLOCK) disable iff (RESET)
		!RD |=> (RDATA == 32'h00000000))
		else $error("Read data outlived their cycle.");

	// The raw copy trails the register by one cycle outside reset.
	AST_BITS_COPY: assert property (@(posedge CLOCK) disable iff (RESET)
		!RESET |=> (DISABLE_BITS == $past(disable_q)))
		else $error("Raw disable copy out of step.");

	// Clearing bit 29 releases the quad serial memory and its clocks.
	AST_QSPI_RELEASE: assert property (@(posedge CLOCK) disable iff (RESET)
		$fell(disable_q[PDB_BIT_QSPI]) |=> (!PERIPH_GATE[8].in_reset && PERIPH_GATE[8].clk_enable))
		else $error("Quad serial memory not released.");

	// Setting bit 0 holds the mesh radio and stops its clocks.
	AST_MESH_HELD: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_MESH]) |=> (PERIPH_GATE[0].in_reset && !PERIPH_GATE[0].clk_enable))
		else $error("Mesh radio not held off.");

	// Setting bit 8 holds the shared converter core and its shared resources.
	AST_CORE_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_CORE]) |=> (PERIPH_GATE[7].in_reset && !PERIPH_GATE[7].clk_enable))
		else $error("Shared converter core not held off.");

	// Setting bit 7 holds the converter controller.
	AST_CONV_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_CONV]) |=> (PERIPH_GATE[6].in_reset && !PERIPH_GATE[6].clk_enable))
		else $error("Converter controller not held off.");

	// Setting bit 6 holds the analog comparator.
	AST_ACMP_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_ACMP]) |=> (PERIPH_GATE[5].in_reset && !PERIPH_GATE[5].clk_enable))
		else $error("Analog comparator not held off.");

	// Setting bit 4 holds the low-voltage detector together with its detector function.
	AST_LVD_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_LVD]) |=> (PERIPH_GATE[4].in_reset && !PERIPH_GATE[4].clk_enable))
		else $error("Low-voltage detector not held off.");

	// Setting bit 3 holds the low-power amplifier.
	AST_LPA_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_LPA]) |=> (PERIPH_GATE[3].in_reset && !PERIPH_GATE[3].clk_enable))
		else $error("Low-power amplifier not held off.");

	// Setting bit 2 holds the medium-power amplifier.
	AST_MPA_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_MPA]) |=> (PERIPH_GATE[2].in_reset && !PERIPH_GATE[2].clk_enable))
		else $error("Medium-power amplifier not held off.");

	// Setting bit 1 holds the short-range radio.
	AST_SRR_GATE: assert property (@(posedge CLOCK) disable iff (RESET)
		$rose(disable_q[PDB_BIT_SRR]) |=> (PERIPH_GATE[1].in_reset && !PERIPH_GATE[1].clk_enable))
		else $error("Short-range radio not held off.");

	// Every gate cell holds its peripheral in reset exactly while its bit is one,
	// and its clock enable is the inverse, one cycle behind the register.
	genvar a;
	generate
		for (a = 0; a < PDB_NUM_PERIPH; a++)
		begin : g_gate_chk
			AST_GATE_HELD: assert property (@(posedge CLOCK) disable iff (RESET)
				!RESET |=> (PERIPH_GATE[a].in_reset == $past(gate_src[a])))
				else $error("Gate reset does not follow its disable bit.");

			AST_GATE_CLOCK: assert property (@(posedge CLOCK) disable iff (RESET)
				!RESET |=> (PERIPH_GATE[a].clk_enable == !$past(gate_src[a])))
				else $error("Gate clock enable does not follow its disable bit.");
		end
	endgenerate

endmodule : pdb_bank

// ==== rtl/pdb_gate.sv ====
// One peripheral's reset and clock-enable cell driven by its disable bit.
`timescale 1ns/1ps
module pdb_gate
	import pdb_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire logic      disable_bit,
	output pdb_gate_t      gate
);

	// Registered so that reset and clock enable move together with no glitch;
	// reset leaves the peripheral held until the bank has loaded its value.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gate <= '{in_reset: 1'b1, clk_enable: 1'b0};
		end
		else
		begin
			gate.in_reset   <= disable_bit;
			gate.clk_enable <= ~disable_bit;
		end
	end

endmodule : pdb_gate

// ==== testbench/pdb_bank_tb.sv ====
// Self-checking testbench for the peripheral disable register bank.
`timescale 1ns/1ps
module pdb_bank_tb
	import pdb_pkg::*;
;
	// An arbitrary variant value, used to show that the reset value is selectable.
	localparam logic [31:0] VAR_RESET = 32'h20000101;
	logic             clock;
	logic             reset;
	logic             wr;
	logic             rd;
	logic             lock;
	logic [7:0]       addr;
	logic [31:0]      wdata;
	logic [31:0]      rdata;
	logic [31:0]      dis_bits;
	logic [31:0]      var_bits;
	logic             rt_off;
	pdb_gate_t [8:0]  gates;
	int               num_errors = 0;
	int               tests_run = 0;
	// Bit position behind each gate element, in element order.
	int bit_pos [9] = '{PDB_BIT_MESH, PDB_BIT_SRR, PDB_BIT_MPA, PDB_BIT_LPA, PDB_BIT_LVD,
		PDB_BIT_ACMP, PDB_BIT_CONV, PDB_BIT_CORE, PDB_BIT_QSPI};

	pdb_bank DUT (.CLOCK(clock), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.WRITE_LOCK(lock), .RDATA(rdata), .DISABLE_BITS(dis_bits), .RT_CALENDAR_OFF(rt_off),
		.PERIPH_GATE(gates));
	// A second variant with another reset value shares the clock, reset and address lines, but its write strobe is tied low.
	pdb_bank #(.RESET_VALUE(VAR_RESET)) DUT_VAR (.CLOCK(clock), .RESET(reset), .ADDR(addr),
		.WDATA(wdata), .WR(1'b0), .RD(rd), .WRITE_LOCK(lock), .RDATA(), .DISABLE_BITS(var_bits),
		.RT_CALENDAR_OFF(), .PERIPH_GATE());

	// The clock toggles every half period of 20 ns, a period of 40 ns.
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// Compares one value and counts the result.
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// One write cycle on the register port.
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// One read cycle; the data stand only in the following cycle, so they are looked at there.
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 chk(rdata, exp, "read data");
	endtask : rd_chk

	// Lets the two register stages behind the bank settle.
	task settle();
		repeat (3) @(posedge clock);
		#1;
	endtask : settle

	task t_reset();
		settle();
		chk(dis_bits, 32'h00000000, "default reset");
		chk(var_bits, VAR_RESET, "variant reset");
		chk(32'(rt_off), 32'h00000000, "calendar flag reset");
		for (int g = 0; g < 9; g++)
			chk(32'(gates[g]), 32'h00000001, "released after reset");
		rd_chk(PDB_ADDR_BASE, 32'h00000000);
	endtask : t_reset

	task t_reserved();
		wr_reg(PDB_ADDR_BASE, 32'hFFFFFFFF);
		settle();
		rd_chk(PDB_ADDR_BASE, PDB_IMPL_MASK);
		chk(32'(rt_off), 32'h00000001, "calendar flag");
		for (int g = 0; g < 9; g++)
			chk(32'(gates[g]), 32'h00000002, "gate held");
	endtask : t_reserved

	task t_alias();
		wr_reg(PDB_ADDR_CLR, 32'h00000101);
		rd_chk(PDB_ADDR_BASE, 32'h200100DE);
		wr_reg(PDB_ADDR_SET, 32'h00000120);
		rd_chk(PDB_ADDR_BASE, 32'h200101DE);
		wr_reg(PDB_ADDR_INV, 32'h20000023);
		rd_chk(PDB_ADDR_BASE, 32'h000101DD);
	endtask : t_alias

	// Each of the nine gated disable bits alone must switch its own peripheral off and leave the next one in index order running.
	task t_bits();
		for (int k = 0; k < 9; k++)
		begin
			// The bench raises no interrupts, so none is pending when a bit is set.
			wr_reg(PDB_ADDR_BASE, 32'h00000001 << bit_pos[k]);
			settle();
			chk(dis_bits, 32'h00000001 << bit_pos[k], "single bit");
			chk(32'(gates[k]), 32'h00000002, "own gate");
			chk(32'(gates[(k + 1) % 9]), 32'h00000001, "other gate");
		end
	endtask : t_bits

	task t_lock();
		wr_reg(PDB_ADDR_BASE, 32'h00000001);
		lock <= 1'b1;
		wr_reg(PDB_ADDR_BASE, 32'h00000080);
		wr_reg(PDB_ADDR_SET, 32'h00000004);
		wr_reg(PDB_ADDR_INV, 32'h00000001);
		rd_chk(PDB_ADDR_BASE, 32'h00000001);
		@(posedge clock);
		lock <= 1'b0;
		wr_reg(8'hD0, 32'hFFFFFFFF);
		rd_chk(8'hD0, 32'h00000000);
		rd_chk(PDB_ADDR_BASE, 32'h00000001);
	endtask : t_lock

	// Prints the counts and the verdict, then stops.
	task end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	initial
	begin
		reset = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		lock = 1'b0;
		addr = 8'h00;
		wdata = 32'h00000000;
		repeat (3) @(posedge clock);
		#1;
		for (int g = 0; g < 9; g++)
			chk(32'(gates[g]), 32'h00000002, "held in reset");
		@(posedge clock);
		reset <= 1'b0;
		t_reset();
		t_reserved();
		t_alias();
		t_bits();
		t_lock();
		end_sim();
	end
endmodule : pdb_bank_tb
